// ===== hdl/ssw_pkg.sv
// Behaviour
// - No watchdog transition for 1.6 s issues 50 ms reset, 200 ms long variant.
// - Without transitions, a fresh reset pulse repeats every 1.6 s.
// - Floating watchdog input disables watchdog resets and expired indication entirely.
// - Watchdog-expired output goes low on timeout, stays low until next transition or until supply falls below threshold.
// - Internal time base gives 1.6 s; external time base input changes the timeout.
// - Active-low reset held asserted while supply is below reset threshold.
// - After supply recovers, reset stays asserted a further 50 ms or 200 ms.
// - Second reset output is always inverse of active-low reset.
// - Power-fail comparator below 1.3 V drives power-fail warning low.
// - Supply above threshold, with main supply above battery, passes incoming chip-enable through to chip-enable output.
// - Supply below threshold forces chip-enable output high regardless of input.
// - Backup status output low whenever main supply exceeds backup battery.
// - Main supply below battery selects backup battery path to switched supply.
// - Battery backup mode holds chip-enable output high at all times.
package ssw_pkg;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int TICK_PERIOD_US  = 1000;
    localparam int TICK_CYCLES     = (TICK_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WD_TIMEOUT_MS   = 1600;
    localparam int PULSE_MS        = 50;
    localparam int LONG_PULSE_MS   = 200;
    localparam int WD_TICKS        = (WD_TIMEOUT_MS * 1000) / TICK_PERIOD_US;
    localparam int PULSE_TICKS     = (PULSE_MS * 1000) / TICK_PERIOD_US;
    localparam int LONG_PULSE_TICKS = (LONG_PULSE_MS * 1000) / TICK_PERIOD_US;

    localparam int DIV_W  = 16;
    localparam int TICK_W = 12;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [DIV_W-1:0]  DIV_RESET  = 16'h0000;
    localparam logic [TICK_W-1:0] TICK_RESET = 12'h000;

    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic supply_low;
        logic powerfail_low;
        logic main_above_backup;
        logic chip_enable_n;
        logic kick;
        logic kick_floating;
        logic timebase;
    } ssw_sense_t;

    localparam ssw_sense_t SENSE_RESET = '{
        supply_low:        1'b1,
        powerfail_low:     1'b1,
        main_above_backup: 1'b1,
        chip_enable_n:     1'b1,
        kick:              1'b0,
        kick_floating:     1'b1,
        timebase:          1'b0
    };

    typedef struct packed {
        logic reset_n;
        logic reset;
        logic powerfail_warn_n;
        logic chip_enable_n;
        logic on_backup_n;
        logic backup_select;
        logic watchdog_expired_n;
    } ssw_out_t;

    localparam ssw_out_t OUT_RESET = '{
        reset_n:            1'b0,
        reset:              1'b1,
        powerfail_warn_n:   1'b0,
        chip_enable_n:      1'b1,
        on_backup_n:        1'b0,
        backup_select:      1'b0,
        watchdog_expired_n: 1'b1
    };

    typedef enum logic [3:0] {
        RST_HOLD    = 4'h1,
        RST_STRETCH = 4'h2,
        RST_RUN     = 4'h4,
        RST_WDPULSE = 4'h8
    } ssw_rst_state_t;

endpackage

// ===== hdl/ssw_top.sv
`timescale 1ns/1ns
`default_nettype none
module ssw_top #(
    parameter int TICK_CYCLES      = ssw_pkg::TICK_CYCLES,
    parameter int WD_TICKS         = ssw_pkg::WD_TICKS,
    parameter int PULSE_TICKS      = ssw_pkg::PULSE_TICKS,
    parameter int LONG_PULSE_TICKS = ssw_pkg::LONG_PULSE_TICKS,
    parameter bit LONG_PULSE       = 1'b0
) (
    input  wire logic sys_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic supply_low_in,
    input  wire logic powerfail_sense_in,
    input  wire logic main_above_backup_in,
    input  wire logic chip_enable_n_in,
    input  wire logic watchdog_kick_in,
    input  wire logic watchdog_floating_in,
    input  wire logic timebase_in,
    input  wire logic timebase_select_in,
    output logic      reset_n_out,
    output logic      reset_out,
    output logic      powerfail_warn_n_out,
    output logic      chip_enable_n_out,
    output logic      on_backup_n_out,
    output logic      backup_select_out,
    output logic      watchdog_expired_n_out
);

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [ssw_pkg::TICK_W-1:0] tick_inc(input logic [ssw_pkg::TICK_W-1:0] v);
        tick_inc = v + 12'h001;
    endfunction

    function automatic logic tick_reached(input logic [ssw_pkg::TICK_W-1:0] v, input int limit);
        tick_reached = (v >= ssw_pkg::TICK_W'(limit - 1));
    endfunction

    // One pulse width serves power-up and watchdog resets
    localparam int PULSE_LEN = LONG_PULSE ? LONG_PULSE_TICKS : PULSE_TICKS;

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    ssw_pkg::ssw_sense_t raw;
    ssw_pkg::ssw_sense_t meta;
    ssw_pkg::ssw_sense_t sense;
    ssw_pkg::ssw_sense_t next_meta;
    ssw_pkg::ssw_sense_t next_sense;
    logic                sel_meta;
    logic                sel_sync;
    logic                next_sel_meta;
    logic                next_sel_sync;

    // Each sensed pin passes meta, then sense, before use; timebase select passes sel_meta, then sel_sync
    always_comb begin
        raw.supply_low        = supply_low_in;
        raw.powerfail_low     = powerfail_sense_in;
        raw.main_above_backup = main_above_backup_in;
        raw.chip_enable_n     = chip_enable_n_in;
        raw.kick              = watchdog_kick_in;
        raw.kick_floating     = watchdog_floating_in;
        raw.timebase          = timebase_in;
        next_meta             = raw;
        next_sense            = meta;
        next_sel_meta         = timebase_select_in;
        next_sel_sync         = sel_meta;
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            meta     <= ssw_pkg::SENSE_RESET;
            sense    <= ssw_pkg::SENSE_RESET;
            sel_meta <= 1'b1;
            sel_sync <= 1'b1;
        end else begin
            meta     <= next_meta;
            sense    <= next_sense;
            sel_meta <= next_sel_meta;
            sel_sync <= next_sel_sync;
        end
    end

    // -----------------------------------------------------------------
    // Time base
    // -----------------------------------------------------------------
    logic [ssw_pkg::DIV_W-1:0] div_cnt;
    logic [ssw_pkg::DIV_W-1:0] next_div_cnt;
    logic                      tb_prev;
    logic                      next_tb_prev;
    logic                      tick;
    logic                      next_tick;

    always_comb begin
        next_div_cnt = div_cnt;
        next_tick    = 1'b0;
        next_tb_prev = sense.timebase;
        // Internal divider, or rising edges of the external clock
        if (sel_sync) begin
            if (div_cnt >= ssw_pkg::DIV_W'(TICK_CYCLES - 1)) begin
                next_div_cnt = ssw_pkg::DIV_RESET;
                next_tick    = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 16'h0001;
            end
        end else begin
            next_div_cnt = ssw_pkg::DIV_RESET;
            next_tick    = sense.timebase & ~tb_prev;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            div_cnt <= ssw_pkg::DIV_RESET;
            tb_prev <= 1'b0;
            tick    <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tb_prev <= next_tb_prev;
            tick    <= next_tick;
        end
    end

    // -----------------------------------------------------------------
    // Watchdog
    // -----------------------------------------------------------------
    logic [ssw_pkg::TICK_W-1:0] wd_cnt;
    logic [ssw_pkg::TICK_W-1:0] next_wd_cnt;
    logic                       kick_prev;
    logic                       next_kick_prev;
    logic                       wd_expired;
    logic                       next_wd_expired;
    logic                       wd_fire;
    logic                       next_wd_fire;
    logic                       kick_edge;
    logic                       wd_enabled;
    logic                       in_hold;

    always_comb begin
        kick_edge       = sense.kick ^ kick_prev;
        wd_enabled      = ~sense.kick_floating;
        next_kick_prev  = sense.kick;
        next_wd_cnt     = wd_cnt;
        next_wd_expired = wd_expired;
        next_wd_fire    = 1'b0;
        if (!wd_enabled || in_hold) begin
            next_wd_cnt     = ssw_pkg::TICK_RESET;
            next_wd_expired = 1'b0;
        end else begin
            // A kick beats a timeout in the same cycle
            if (kick_edge) begin
                next_wd_cnt     = ssw_pkg::TICK_RESET;
                next_wd_expired = 1'b0;
            end else if (tick) begin
                if (tick_reached(wd_cnt, WD_TICKS)) begin
                    // Count runs on through the pulse, so resets repeat
                    next_wd_cnt = ssw_pkg::TICK_RESET;
                    next_wd_fire = 1'b1;
                end else begin
                    next_wd_cnt = tick_inc(wd_cnt);
                end
            end
            if (next_wd_fire) begin
                next_wd_expired = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wd_cnt     <= ssw_pkg::TICK_RESET;
            kick_prev  <= 1'b0;
            wd_expired <= 1'b0;
            wd_fire    <= 1'b0;
        end else begin
            wd_cnt     <= next_wd_cnt;
            kick_prev  <= next_kick_prev;
            wd_expired <= next_wd_expired;
            wd_fire    <= next_wd_fire;
        end
    end

    // -----------------------------------------------------------------
    // Reset sequencer
    // -----------------------------------------------------------------
    ssw_pkg::ssw_rst_state_t    rst_state;
    ssw_pkg::ssw_rst_state_t    next_rst_state;
    logic [ssw_pkg::TICK_W-1:0] rst_cnt;
    logic [ssw_pkg::TICK_W-1:0] next_rst_cnt;

    always_comb begin
        next_rst_state = rst_state;
        next_rst_cnt   = rst_cnt;
        in_hold        = (rst_state == ssw_pkg::RST_HOLD);
        // Low supply drops back to hold from any state
        case (rst_state)
            ssw_pkg::RST_HOLD: begin
                next_rst_cnt = ssw_pkg::TICK_RESET;
                if (!sense.supply_low) begin
                    next_rst_state = ssw_pkg::RST_STRETCH;
                end
            end
            ssw_pkg::RST_STRETCH: begin
                if (sense.supply_low) begin
                    next_rst_state = ssw_pkg::RST_HOLD;
                end else if (tick) begin
                    if (tick_reached(rst_cnt, PULSE_LEN)) begin
                        next_rst_state = ssw_pkg::RST_RUN;
                    end else begin
                        next_rst_cnt = tick_inc(rst_cnt);
                    end
                end
            end
            ssw_pkg::RST_RUN: begin
                next_rst_cnt = ssw_pkg::TICK_RESET;
                if (sense.supply_low) begin
                    next_rst_state = ssw_pkg::RST_HOLD;
                end else if (wd_fire) begin
                    next_rst_state = ssw_pkg::RST_WDPULSE;
                end
            end
            ssw_pkg::RST_WDPULSE: begin
                if (sense.supply_low) begin
                    next_rst_state = ssw_pkg::RST_HOLD;
                end else if (tick) begin
                    if (tick_reached(rst_cnt, PULSE_LEN)) begin
                        next_rst_state = ssw_pkg::RST_RUN;
                    end else begin
                        next_rst_cnt = tick_inc(rst_cnt);
                    end
                end
            end
            // Stray code falls back to holding reset
            default: begin
                next_rst_state = ssw_pkg::RST_HOLD;
                next_rst_cnt   = ssw_pkg::TICK_RESET;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rst_state <= ssw_pkg::RST_HOLD;
            rst_cnt   <= ssw_pkg::TICK_RESET;
        end else begin
            rst_state <= next_rst_state;
            rst_cnt   <= next_rst_cnt;
        end
    end

    // -----------------------------------------------------------------
    // Output stage
    // -----------------------------------------------------------------
    ssw_pkg::ssw_out_t outs;
    ssw_pkg::ssw_out_t next_outs;
    logic              rst_active;
    logic              on_backup;

    always_comb begin
        // Reset pins follow the next state, no added lag
        // Expiry shows one edge before the watchdog reset
        rst_active                   = (next_rst_state != ssw_pkg::RST_RUN);
        on_backup                    = ~sense.main_above_backup;
        next_outs.reset_n            = ~rst_active;
        next_outs.reset              = rst_active;
        next_outs.powerfail_warn_n   = ~sense.powerfail_low;
        next_outs.on_backup_n        = on_backup;
        next_outs.backup_select      = on_backup;
        next_outs.watchdog_expired_n = ~next_wd_expired;
        // RAM stays deselected on low supply and on battery
        if (sense.supply_low) begin
            next_outs.chip_enable_n = 1'b1;
        end else if (on_backup) begin
            next_outs.chip_enable_n = 1'b1;
        end else begin
            next_outs.chip_enable_n = sense.chip_enable_n;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            outs <= ssw_pkg::OUT_RESET;
        end else begin
            outs <= next_outs;
        end
    end

    // -----------------------------------------------------------------
    // Port drive
    // -----------------------------------------------------------------
    always_comb begin
        reset_n_out            = outs.reset_n;
        reset_out              = outs.reset;
        powerfail_warn_n_out   = outs.powerfail_warn_n;
        chip_enable_n_out      = outs.chip_enable_n;
        on_backup_n_out        = outs.on_backup_n;
        backup_select_out      = outs.backup_select;
        watchdog_expired_n_out = outs.watchdog_expired_n;
    end

endmodule
`default_nettype wire

// ===== tb/ssw_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ssw_chk #(
    parameter int TICK_CYCLES = 4,
    parameter int PULSE_TICKS = 2
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic supply_low_in,
    input wire logic main_above_backup_in,
    input wire logic watchdog_kick_in,
    input wire logic watchdog_floating_in,
    input wire logic reset_n_out,
    input wire logic reset_out,
    input wire logic chip_enable_n_out,
    input wire logic watchdog_expired_n_out
);
    localparam int PULSE_MAX = (PULSE_TICKS + 1) * TICK_CYCLES + 4;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    chk_reset_pair: assert property (reset_out == !reset_n_out)
        else $error("reset outputs not complementary");
    chk_supply_hold: assert property (supply_low_in [*3] |=> !reset_n_out)
        else $error("reset released while supply low");
    chk_stretch_min: assert property (!supply_low_in [*6] ##0 $past(supply_low_in, 6) |-> !reset_n_out)
        else $error("reset released too soon");
    chk_ce_blocked:
        assert property ((supply_low_in || !main_above_backup_in) [*3] |=> chip_enable_n_out)
        else $error("chip enable not blocked");
    chk_wd_float: assert property (watchdog_floating_in [*5] |=> watchdog_expired_n_out)
        else $error("watchdog expired while disabled");
    chk_wd_reset: assert property ($fell(watchdog_expired_n_out) |=> $fell(reset_n_out))
        else $error("expiry without reset");
    chk_pulse_len:
        assert property ($fell(watchdog_expired_n_out) |=> !reset_n_out [*4] ##[1:PULSE_MAX] reset_n_out)
        else $error("watchdog reset pulse length wrong");
    chk_wd_hold:
        assert property (($stable(watchdog_kick_in) && !watchdog_floating_in && !supply_low_in) [*5]
            ##0 !watchdog_expired_n_out |=> !watchdog_expired_n_out)
        else $error("expired flag cleared without kick");
endmodule

bind ssw_top ssw_chk #(.TICK_CYCLES(TICK_CYCLES), .PULSE_TICKS(PULSE_TICKS)) i_chk (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .supply_low_in(supply_low_in),
    .main_above_backup_in(main_above_backup_in), .watchdog_kick_in(watchdog_kick_in),
    .watchdog_floating_in(watchdog_floating_in), .reset_n_out(reset_n_out), .reset_out(reset_out),
    .chip_enable_n_out(chip_enable_n_out), .watchdog_expired_n_out(watchdog_expired_n_out)
);
`default_nettype wire

// ===== tb/ssw_host.sv
`timescale 1ns/1ns
`default_nettype none
module ssw_host #(
    parameter int KICK_GAP = 20
) (
    input  wire logic clk_in,
    input  wire logic run_in,
    input  wire logic ce_req_n_in,
    output var logic  kick_out,
    output var logic  ce_n_out
);
    int gap = 0;
    initial kick_out = 1'b0;
    initial ce_n_out = 1'b1;
    // Processor side: flips the kick line well inside the timeout
    always @(posedge clk_in) begin
        #1;
        ce_n_out = ce_req_n_in;
        gap = run_in ? gap + 1 : 0;
        if (gap == KICK_GAP) begin
            kick_out = ~kick_out;
            gap = 0;
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int TC = 4;
    localparam int WT = 8;
    typedef struct {
        int                t;
        ssw_pkg::ssw_out_t m;
        ssw_pkg::ssw_out_t v;
    } ssw_exp_t;
    logic              sys_clk_in = 1'b0, sys_rst_in = 1'b1, supply_low = 1'b1, pf_sense = 1'b0;
    logic              main_above = 1'b1, ce_req_n = 1'b1, floating = 1'b0, timebase = 1'b0;
    logic              tb_sel = 1'b1, run = 1'b0;
    logic [7:0]        seed = 8'h5b;
    wire logic         kick, ce_n;
    wire ssw_pkg::ssw_out_t o;
    ssw_exp_t          q[$], e;
    int                cyc = 0, n_errors = 0, n_tests = 0, n, gap;

    always #50 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        #1;
        if ((cyc % 4) == 0)
            timebase = ~timebase;
    end

    ssw_top #(.TICK_CYCLES(TC), .WD_TICKS(WT), .PULSE_TICKS(2)) i_dut (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .supply_low_in(supply_low),
        .powerfail_sense_in(pf_sense), .main_above_backup_in(main_above), .chip_enable_n_in(ce_n),
        .watchdog_kick_in(kick), .watchdog_floating_in(floating), .timebase_in(timebase),
        .timebase_select_in(tb_sel), .reset_n_out(o.reset_n), .reset_out(o.reset),
        .powerfail_warn_n_out(o.powerfail_warn_n), .chip_enable_n_out(o.chip_enable_n),
        .on_backup_n_out(o.on_backup_n), .backup_select_out(o.backup_select),
        .watchdog_expired_n_out(o.watchdog_expired_n)
    );
    ssw_host i_host (.clk_in(sys_clk_in), .run_in(run), .ce_req_n_in(ce_req_n), .kick_out(kick), .ce_n_out(ce_n));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [6:0] seen, input logic [6:0] want);
        n_tests++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic wait_bit(input int b, input logic v, input int lim, output int k);
        for (k = 0; o[b] !== v && k < lim; k++)
            tick(1);
        if (o[b] !== v) begin
            n_errors++;
            $display("BAD t=%0t output bit %0d never reached %b", $time, b, v);
            give_verdict();
        end
    endtask

    // Noted results fall due at a known cycle
    always @(posedge sys_clk_in) begin
        cyc++;
        #1;
        while (q.size() > 0 && q[0].t <= cyc) begin
            check(o & q[0].m, q[0].v & q[0].m);
            void'(q.pop_front());
        end
    end

    initial begin
        tick(3);
        sys_rst_in = 1'b0;
        run = 1'b1;
        tick(10);
        check(o & 7'h60, 7'h20);
        supply_low = 1'b0;
        tick(6);
        check(o & 7'h60, 7'h20);
        wait_bit(6, 1'b1, 20, n);
        check(o & 7'h60, 7'h40);
        $display("stretch test done");
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            {supply_low, pf_sense, main_above, ce_req_n} = seed[3:0];
            e.t = cyc + 5;
            e.m = supply_low ? 7'h7f : 7'h1f;
            e.v = {2'b01, ~pf_sense, supply_low | ~main_above | ce_req_n, ~main_above, ~main_above, 1'b1};
            q.push_back(e);
            tick(5);
        end
        {supply_low, pf_sense, main_above} = 3'h1;
        wait_bit(6, 1'b1, 20, n);
        $display("mirror test done");
        repeat (10) begin
            tick(10);
            check(o & 7'h41, 7'h41);
        end
        $display("kick test done");
        run = 1'b0;
        wait_bit(0, 1'b0, 60, n);
        tick(1);
        check(o & 7'h41, 7'h00);
        for (int r = 0; r < 2; r++) begin
            wait_bit(6, 1'b1, 20, gap);
            check(o & 7'h41, 7'h40);
            wait_bit(6, 1'b0, 40, n);
            check({6'h00, gap + n >= WT * TC - TC && gap + n <= WT * TC + TC}, 7'h01);
        end
        run = 1'b1;
        wait_bit(0, 1'b1, 30, n);
        $display("expiry test done");
        {floating, run} = 2'h2;
        repeat (10) begin
            tick(10);
            check(o & 7'h41, 7'h41);
        end
        $display("floating test done");
        {floating, tb_sel} = 2'h0;
        tick(48);
        check(o & 7'h01, 7'h01);
        wait_bit(0, 1'b0, 40, n);
        $display("time base test done");
        give_verdict();
    end
endmodule
`default_nettype wire
